// ===== core/rsw_top.sv
// Reset supervisor: merges pin, low-voltage, USB bus reset and watchdog resets.
// Assumes the processor writes its registers through a simple SFR write port
// and that the low-voltage detector and USB line state come from analog cells.
//
// How it works
// - Any enabled source raises one internal reset for the processor.
// - The internal reset also goes out active low to the memory module.
// - Reset is held 10 ms after supply recovers above threshold.
// - Low-voltage reset is enabled at power-up; software may disable it.
// - Low-voltage reset keeps working in idle and power-down modes.
// - Single-ended zero seen four times sets the bus reset flag.
// - With enable bit 6 set, bus reset also raises internal reset.
// - Watchdog is a 22-bit counter advancing once per machine cycle.
// - Watchdog overflow from all ones raises the internal reset.
// - Watchdog starts enabled after power-up and every reset.
// - Clear register write loads seven bits into counter top; 00h-7Eh.
// - Writing zero to the clear register zeroes the whole counter.
// - Only key 55h disables the watchdog; other values keep it on.
// - Watchdog and reset logic stay active in idle mode.
// - Watchdog reset pulse lasts 12 times 2^15 oscillator periods.
// - One machine cycle equals twelve oscillator periods.
// - Processor resumes three machine cycles after internal reset ends.
`default_nettype none
module rsw_top
	import rsw_pkg::*;
#(
	parameter int LVR_HOLD = LVR_HOLD_CYCLES,
	parameter int WD_PULSE = WD_PULSE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic reset_pin_n,
	input wire logic supply_low,
	input wire logic usb_se0,
	input wire logic idle_mode,
	input wire logic power_down_mode,
	input wire logic low_voltage_reset_enable,
	input wire logic [7:0] usb_interrupt_enable,
	input wire logic bus_reset_flag_clear,
	input wire rsw_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	output logic bus_reset_flag,
	output logic cpu_reset,
	output logic module_reset_n,
	output logic watchdog_running
);

	rsw_state_t s;
	rsw_state_t next_s;

	logic mc_tick;
	logic wd_enabled;
	logic wd_overflow;
	logic clear_wr;
	logic key_wr;
	logic src_lvr;
	logic src_usb;
	logic lvr_active;
	logic se0_done;

	// ------------------------------------------------------------
	// Source qualification
	// ------------------------------------------------------------
	// The supply detector and its enable are read regardless of idle or
	// power-down, so the low-voltage path is never gated by them.
	assign mc_tick = (s.mc_div == MC_DIV_LAST);
	assign wd_enabled = (s.wd_key != WD_KEY_DISABLE);
	assign wd_overflow = mc_tick && wd_enabled && (&s.wd_count);
	assign clear_wr = sfr_req.wr && (sfr_req.addr == OFS_WD_CLEAR);
	assign key_wr = sfr_req.wr && (sfr_req.addr == OFS_WD_KEY);
	assign lvr_active = low_voltage_reset_enable && s.lvd_sync[1];
	assign src_lvr = lvr_active || (s.lvr_cnt != '0);
	assign se0_done = s.se0_sync[1] && (s.se0_cnt == SE0_MIN_CNT - 4'h1) && mc_tick;
	assign src_usb = se0_done && usb_interrupt_enable[USB_BUS_RESET_ENABLE_BIT];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.rst_pin_sync = {s.rst_pin_sync[0], ~reset_pin_n};
		next_s.lvd_sync = {s.lvd_sync[0], supply_low};
		next_s.se0_sync = {s.se0_sync[0], usb_se0};
		next_s.mc_div = mc_tick ? 4'h0 : s.mc_div + 4'h1;

		// Line sampled once per machine cycle; flag set wins over clear.
		if (!s.se0_sync[1]) begin
			next_s.se0_cnt = 4'h0;
		end else if (mc_tick && s.se0_cnt != SE0_MIN_CNT) begin
			next_s.se0_cnt = s.se0_cnt + 4'h1;
		end
		if (se0_done) begin
			next_s.bus_reset_flag = 1'b1;
		end else if (bus_reset_flag_clear) begin
			next_s.bus_reset_flag = 1'b0;
		end

		// Hold counter reloads while the supply is low and its reset is enabled, then runs out.
		if (lvr_active) begin
			next_s.lvr_cnt = CNT_W'(LVR_HOLD);
		end else if (s.lvr_cnt != '0) begin
			next_s.lvr_cnt = s.lvr_cnt - 1'b1;
		end

		if (wd_overflow) begin
			next_s.wd_pulse_cnt = CNT_W'(WD_PULSE);
		end else if (s.wd_pulse_cnt != '0) begin
			next_s.wd_pulse_cnt = s.wd_pulse_cnt - 1'b1;
		end

		if (key_wr) begin
			next_s.wd_key = sfr_req.wdata;
		end

		// Counter ignores idle mode: only the key stops it.
		if (s.internal_reset) begin
			next_s.wd_count = '0;
			next_s.wd_key = WD_KEY_RESET;
		end else if (clear_wr) begin
			if (sfr_req.wdata[6:0] == 7'h00) begin
				next_s.wd_count = '0;
			end else if (sfr_req.wdata[6:0] <= WD_CLEAR_MAX) begin
				next_s.wd_count = {sfr_req.wdata[6:0], 15'h0000};
			end
		end else if (mc_tick && wd_enabled) begin
			next_s.wd_count = s.wd_count + 1'b1;
		end

		next_s.internal_reset = s.rst_pin_sync[1] || src_lvr || src_usb
			|| wd_overflow || (s.wd_pulse_cnt > CNT_W'(1));

		// Processor stays held for three machine cycles after release.
		if (s.internal_reset) begin
			next_s.resume_cnt = 2'(RESUME_MC);
			next_s.cpu_hold = 1'b1;
		end else if (s.resume_cnt != 2'h0) begin
			if (mc_tick) begin
				next_s.resume_cnt = s.resume_cnt - 2'h1;
			end
		end else begin
			next_s.cpu_hold = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
			s.internal_reset <= 1'b1;
			s.cpu_hold <= 1'b1;
			s.resume_cnt <= 2'h3;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign cpu_reset = s.cpu_hold;
	assign module_reset_n = ~s.internal_reset;
	assign bus_reset_flag = s.bus_reset_flag;
	assign watchdog_running = wd_enabled;

	always_comb begin
		case (sfr_req.addr)
			OFS_WD_CLEAR: sfr_rdata = {1'b0, s.wd_count[WD_WIDTH-1:WD_LOAD_POS]};
			OFS_WD_KEY: sfr_rdata = s.wd_key;
			default: sfr_rdata = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_module_follows;
		@(posedge sys_clk) disable iff (sys_rst)
		module_reset_n == !s.internal_reset;
	endproperty
	a_module_follows: assert property (p_module_follows) else $error("module reset wrong");

	property p_overflow_resets;
		@(posedge sys_clk) disable iff (sys_rst)
		wd_overflow |=> s.internal_reset;
	endproperty
	a_overflow_resets: assert property (p_overflow_resets) else $error("no reset on overflow");

	property p_reset_clears;
		@(posedge sys_clk) disable iff (sys_rst)
		s.internal_reset |=> (s.wd_count == '0) && wd_enabled;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("watchdog not cleared");

	property p_key_disables;
		@(posedge sys_clk) disable iff (sys_rst)
		(!wd_enabled && !s.internal_reset && !clear_wr) |=> $stable(s.wd_count);
	endproperty
	a_key_disables: assert property (p_key_disables) else $error("disabled watchdog moved");

	property p_count_step;
		@(posedge sys_clk) disable iff (sys_rst)
		(mc_tick && wd_enabled && !s.internal_reset && !clear_wr && !(&s.wd_count))
		|=> s.wd_count == $past(s.wd_count) + 1'b1;
	endproperty
	a_count_step: assert property (p_count_step) else $error("watchdog step wrong");

	property p_zero_clear;
		@(posedge sys_clk) disable iff (sys_rst)
		(clear_wr && sfr_req.wdata[6:0] == 7'h00 && !s.internal_reset) |=> s.wd_count == '0;
	endproperty
	a_zero_clear: assert property (p_zero_clear) else $error("zero write kept count");

	property p_load_top;
		@(posedge sys_clk) disable iff (sys_rst)
		(clear_wr && sfr_req.wdata[6:0] != 7'h00 && sfr_req.wdata[6:0] <= WD_CLEAR_MAX
			&& !s.internal_reset)
		|=> s.wd_count == {$past(sfr_req.wdata[6:0]), 15'h0000};
	endproperty
	a_load_top: assert property (p_load_top) else $error("clear load wrong");

	property p_lvr_holds;
		@(posedge sys_clk) disable iff (sys_rst)
		$fell(lvr_active) |=> s.internal_reset [*8];
	endproperty
	a_lvr_holds: assert property (p_lvr_holds) else $error("lvr released early");

	property p_usb_flag;
		@(posedge sys_clk) disable iff (sys_rst)
		se0_done |=> bus_reset_flag;
	endproperty
	a_usb_flag: assert property (p_usb_flag) else $error("bus reset flag missed");

	// The release delay is checked through the resume counter and the tick
	// spacing, so no long repetition has to be unrolled.
	property p_resume_load;
		@(posedge sys_clk) disable iff (sys_rst)
		$fell(s.internal_reset) |-> cpu_reset && (s.resume_cnt == 2'(RESUME_MC));
	endproperty
	a_resume_load: assert property (p_resume_load) else $error("resume count not loaded");

	property p_resume_hold;
		@(posedge sys_clk) disable iff (sys_rst)
		(s.resume_cnt != 2'h0) |-> cpu_reset;
	endproperty
	a_resume_hold: assert property (p_resume_hold) else $error("cpu released early");

	property p_resume_step;
		@(posedge sys_clk) disable iff (sys_rst)
		(!s.internal_reset && s.resume_cnt != 2'h0 && !mc_tick) |=> $stable(s.resume_cnt);
	endproperty
	a_resume_step: assert property (p_resume_step) else $error("resume count moved");

	property p_resume_end;
		@(posedge sys_clk) disable iff (sys_rst)
		(!s.internal_reset && s.resume_cnt == 2'h0) |=> !cpu_reset;
	endproperty
	a_resume_end: assert property (p_resume_end) else $error("cpu held too long");

	property p_tick_wrap;
		@(posedge sys_clk) disable iff (sys_rst)
		mc_tick |=> (s.mc_div == 4'h0);
	endproperty
	a_tick_wrap: assert property (p_tick_wrap) else $error("divider did not wrap");

	property p_tick_step;
		@(posedge sys_clk) disable iff (sys_rst)
		(s.mc_div != MC_DIV_LAST) |=> (s.mc_div == $past(s.mc_div) + 4'h1);
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("divider step wrong");

	property p_tick_range;
		@(posedge sys_clk) disable iff (sys_rst)
		s.mc_div <= MC_DIV_LAST;
	endproperty
	a_tick_range: assert property (p_tick_range) else $error("divider out of range");

	// ------------------------------------------------------------
	// Source assertions
	// ------------------------------------------------------------
	property p_idle_counts;
		@(posedge sys_clk) disable iff (sys_rst)
		(idle_mode && mc_tick && wd_enabled && !s.internal_reset && !clear_wr)
		|=> s.wd_count == $past(s.wd_count) + 1'b1;
	endproperty
	a_idle_counts: assert property (p_idle_counts) else $error("idle stopped watchdog");

	property p_lvr_power_down;
		@(posedge sys_clk) disable iff (sys_rst)
		(power_down_mode && lvr_active) |=> s.internal_reset;
	endproperty
	a_lvr_power_down: assert property (p_lvr_power_down) else $error("sleep lvr lost");

	property p_lvr_reload;
		@(posedge sys_clk) disable iff (sys_rst)
		lvr_active |=> (s.lvr_cnt == CNT_W'(LVR_HOLD));
	endproperty
	a_lvr_reload: assert property (p_lvr_reload) else $error("lvr hold not loaded");

	property p_pin_reset;
		@(posedge sys_clk) disable iff (sys_rst)
		s.rst_pin_sync[1] |=> s.internal_reset;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("pin reset missed");

	property p_cpu_follows;
		@(posedge sys_clk) disable iff (sys_rst)
		s.internal_reset |=> cpu_reset;
	endproperty
	a_cpu_follows: assert property (p_cpu_follows) else $error("cpu not held");

	property p_usb_reset;
		@(posedge sys_clk) disable iff (sys_rst)
		(se0_done && usb_interrupt_enable[USB_BUS_RESET_ENABLE_BIT]) |=> s.internal_reset;
	endproperty
	a_usb_reset: assert property (p_usb_reset) else $error("bus reset not applied");

	property p_pulse_load;
		@(posedge sys_clk) disable iff (sys_rst)
		wd_overflow |=> (s.wd_pulse_cnt == CNT_W'(WD_PULSE));
	endproperty
	a_pulse_load: assert property (p_pulse_load) else $error("pulse count not loaded");

	property p_pulse_holds;
		@(posedge sys_clk) disable iff (sys_rst)
		(s.wd_pulse_cnt > CNT_W'(1)) |=> s.internal_reset;
	endproperty
	a_pulse_holds: assert property (p_pulse_holds) else $error("pulse cut short");

	property p_flag_sticky;
		@(posedge sys_clk) disable iff (sys_rst)
		(bus_reset_flag && !bus_reset_flag_clear) |=> bus_reset_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

	property p_se0_restart;
		@(posedge sys_clk) disable iff (sys_rst)
		!s.se0_sync[1] |=> (s.se0_cnt == 4'h0);
	endproperty
	a_se0_restart: assert property (p_se0_restart) else $error("line count kept");

	property p_refuse_top;
		@(posedge sys_clk) disable iff (sys_rst)
		(clear_wr && sfr_req.wdata[6:0] == 7'h7f && !s.internal_reset && !mc_tick)
		|=> $stable(s.wd_count);
	endproperty
	a_refuse_top: assert property (p_refuse_top) else $error("refused load taken");

endmodule
`default_nettype wire

// ===== core/rsw_pkg.sv
// Package for the reset supervisor and watchdog block.
// Assumes a single 25 MHz system clock that also serves as the oscillator.
`default_nettype none
package rsw_pkg;
	// Oscillator period in ns and the machine-cycle ratio.
	localparam int OSC_PERIOD_NS = 40;
	localparam int OSC_PER_MACHINE = 12;
	localparam logic [3:0] MC_DIV_LAST = 4'(OSC_PER_MACHINE - 1);
	// Register offsets on the special function register port.
	localparam logic [7:0] OFS_WD_CLEAR = 8'ha6;
	localparam logic [7:0] OFS_WD_KEY = 8'hae;
	localparam logic [7:0] WD_KEY_RESET = 8'h00;
	localparam logic [7:0] WD_KEY_DISABLE = 8'h55;
	localparam logic [6:0] WD_CLEAR_MAX = 7'h7e;
	localparam int WD_WIDTH = 22;
	localparam int WD_LOAD_POS = 15;
	localparam int USB_BUS_RESET_ENABLE_BIT = 6;
	// Timing.
	localparam int LVR_HOLD_MS = 10;
	localparam int LVR_HOLD_CYCLES = LVR_HOLD_MS * 1000000 / OSC_PERIOD_NS;
	localparam int WD_PULSE_CYCLES = OSC_PER_MACHINE * (2 ** 15);
	localparam int RESUME_MC = 3;
	localparam int SE0_MIN = 4;
	localparam logic [3:0] SE0_MIN_CNT = 4'(SE0_MIN);
	localparam int CNT_W = 20;

	typedef struct packed {
		logic [3:0] mc_div;
		logic [WD_WIDTH-1:0] wd_count;
		logic [7:0] wd_key;
		logic [CNT_W-1:0] lvr_cnt;
		logic [CNT_W-1:0] wd_pulse_cnt;
		logic [1:0] resume_cnt;
		logic [3:0] se0_cnt;
		logic bus_reset_flag;
		logic internal_reset;
		logic cpu_hold;
		logic [1:0] rst_pin_sync;
		logic [1:0] lvd_sync;
		logic [1:0] se0_sync;
	} rsw_state_t;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rsw_sfr_req_t;
endpackage
`default_nettype wire

// ===== testbench/rsw_top_test.sv
// Self-checking bench for the reset supervisor and watchdog block.
// Assumes the block is built with short low-voltage and pulse counts.
`default_nettype none
module rsw_top_test
	import rsw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 20;
	localparam int PIN_LOW = 25000;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] rd;
		logic run;
	} rsw_row_t;
	logic sys_clk, sys_rst, reset_pin_n, supply_low, usb_se0, idle_mode, power_down_mode;
	logic low_voltage_reset_enable, bus_reset_flag_clear;
	logic [7:0] usb_interrupt_enable, sfr_rdata;
	rsw_sfr_req_t sfr_req;
	logic bus_reset_flag, cpu_reset, module_reset_n, watchdog_running;
	int error_cnt = 0;
	int compares = 0;
	// A clear write of 7Fh is refused and bit 7 of 85h is dropped, so 05h must survive.
	rsw_row_t rows[8] = '{'{8'ha6, 8'h10, 8'h10, 1'b1}, '{8'ha6, 8'h85, 8'h05, 1'b1},
		'{8'ha6, 8'h7f, 8'h05, 1'b1}, '{8'ha6, 8'h00, 8'h00, 1'b1},
		'{8'hae, 8'h55, 8'h55, 1'b0}, '{8'hae, 8'h54, 8'h54, 1'b1},
		'{8'hae, 8'haa, 8'haa, 1'b1}, '{8'h30, 8'h12, 8'h00, 1'b1}};

	rsw_top #(.LVR_HOLD(HOLD), .WD_PULSE(20)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reset_pin_n(reset_pin_n), .supply_low(supply_low), .usb_se0(usb_se0),
		.idle_mode(idle_mode), .power_down_mode(power_down_mode),
		.low_voltage_reset_enable(low_voltage_reset_enable),
		.usb_interrupt_enable(usb_interrupt_enable), .bus_reset_flag_clear(bus_reset_flag_clear),
		.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .bus_reset_flag(bus_reset_flag),
		.cpu_reset(cpu_reset), .module_reset_n(module_reset_n),
		.watchdog_running(watchdog_running));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic test_done();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Waits on cpu_reset (sel high) or module_reset_n; a spent bound ends the run.
	task automatic wait_for(input logic sel, input logic val, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(negedge sys_clk);
			if ((sel ? cpu_reset : module_reset_n) === val) break;
		end
		if (i == n) begin
			error_cnt++;
			$display("[ERR] %0t wait ran out", $time);
			test_done();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_req <= '{1'b1, a, d};
		@(posedge sys_clk);
		sfr_req.wr <= 1'b0;
	endtask

	initial begin
		{sys_rst, reset_pin_n, supply_low, usb_se0, idle_mode, power_down_mode} = 6'b110000;
		{low_voltage_reset_enable, bus_reset_flag_clear, usb_interrupt_enable} = 10'h200;
		sfr_req = '{1'b0, OFS_WD_KEY, 8'h00};
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		chk({7'h0, cpu_reset}, 8'h01, "cpu reset");
		chk({7'h0, module_reset_n}, 8'h00, "module reset");
		chk({sfr_rdata[7:1], watchdog_running}, 8'h01, "key after reset");
		@(posedge sys_clk) sys_rst <= 1'b0;
		wait_for(1'b1, 1'b0, 45);
		$display("test reset done");
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d);
			@(negedge sys_clk);
			chk(sfr_rdata, rows[k].rd, "read back");
			chk({7'h0, watchdog_running}, {7'h0, rows[k].run}, "running");
		end
		$display("test registers done");
		wr(OFS_WD_KEY, WD_KEY_DISABLE);
		wr(OFS_WD_CLEAR, 8'h33);
		@(posedge sys_clk) reset_pin_n <= 1'b0;
		wait_for(1'b0, 1'b0, 6);
		repeat (PIN_LOW) @(negedge sys_clk);
		chk({7'h0, module_reset_n}, 8'h00, "pin hold");
		@(posedge sys_clk) reset_pin_n <= 1'b1;
		wait_for(1'b0, 1'b1, 6);
		wait_for(1'b1, 1'b0, 45);
		@(posedge sys_clk) sfr_req.addr <= OFS_WD_KEY;
		@(negedge sys_clk);
		chk(sfr_rdata, 8'h00, "key cleared");
		chk({7'h0, watchdog_running}, 8'h01, "running again");
		@(posedge sys_clk) sfr_req.addr <= OFS_WD_CLEAR;
		@(negedge sys_clk);
		chk(sfr_rdata, 8'h00, "counter cleared");
		$display("test pin done");
		@(posedge sys_clk) {idle_mode, power_down_mode, supply_low} <= 3'b111;
		wait_for(1'b0, 1'b0, 6);
		@(posedge sys_clk) supply_low <= 1'b0;
		repeat (HOLD) @(negedge sys_clk);
		chk({7'h0, module_reset_n}, 8'h00, "low voltage hold");
		wait_for(1'b0, 1'b1, 10);
		wait_for(1'b1, 1'b0, 45);
		@(posedge sys_clk) {low_voltage_reset_enable, supply_low} <= 2'b01;
		repeat (10) @(negedge sys_clk);
		chk({7'h0, cpu_reset}, 8'h00, "low voltage disabled");
		@(posedge sys_clk) supply_low <= 1'b0;
		repeat (4) @(posedge sys_clk);
		{low_voltage_reset_enable, usb_se0} <= 2'b11;
		repeat (72) @(negedge sys_clk);
		chk({6'h0, bus_reset_flag, cpu_reset}, 8'h02, "bus reset flag only");
		@(posedge sys_clk) {usb_se0, bus_reset_flag_clear} <= 2'b01;
		@(posedge sys_clk) bus_reset_flag_clear <= 1'b0;
		@(negedge sys_clk);
		chk({7'h0, bus_reset_flag}, 8'h00, "flag cleared");
		@(posedge sys_clk) {usb_interrupt_enable, usb_se0} <= {8'h40, 1'b1};
		wait_for(1'b1, 1'b1, 90);
		@(posedge sys_clk) usb_se0 <= 1'b0;
		wait_for(1'b1, 1'b0, 80);
		$display("test sources done");
		test_done();
	end
endmodule
`default_nettype wire
